/* File: logic/arsm_pkg.sv */
// Contract
// - clock fail event sets status bit 2
// - rx interrupt high while any enabled error flag is set
// - writing 1 clears an error flag, writing 0 leaves it
// - frame sync arriving before slot count ends sets status bit 1
// - buffer load while previous word unread sets status bit 0
// - slot register shows slot count in bits 9-0, rest zero
// - slot counter runs 0 to 383
// - reserved bits read 0, writes to them ignored
// - status bit 8 is OR of overrun, early sync, clock fail, dma error
// - status bit 3 is lsb of current slot count
package arsm_pkg;
   localparam logic [3:0] ADDR_STATUS = 4'h0;
   localparam logic [3:0] ADDR_SLOT = 4'h4;
   localparam logic [3:0] ADDR_INT_EN = 4'h8;
   localparam logic [3:0] ADDR_CTRL = 4'hc;
   localparam int BIT_OVERRUN = 0;
   localparam int BIT_EARLY_SYNC = 1;
   localparam int BIT_CLK_FAIL = 2;
   localparam int BIT_PARITY = 3;
   localparam int BIT_DMA_ERR = 7;
   localparam int BIT_ANY_ERR = 8;
   localparam int SLOT_W = 10;
   localparam logic [9:0] SLOT_MAX = 10'h17f;
   localparam logic [9:0] SLOT_RESET = 10'h000;
   localparam logic [9:0] SLOTS_DEFAULT = 10'h002;
   localparam logic [2:0] FLAGS_RESET = 3'h0;

   typedef struct packed {
      logic [3:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } arsm_bus_t;

   typedef struct packed {
      logic clkFail;
      logic earlySync;
      logic overrun;
   } arsm_evt_t;
endpackage : arsm_pkg

/* File: logic/arsm_top.sv */
`timescale 1ns/1ps
module arsm_top (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // register port
   input wire arsm_pkg::arsm_bus_t bus,
   output logic [31:0] rdata,
   // link pins, asynchronous to clk
   input wire logic rxBitClk,
   input wire logic rxFrameSync,
   // events from neighbouring logic on clk
   input wire logic clkFailEvt,
   input wire logic dmaErrFlag,
   input wire logic bufferLoad,
   input wire logic bufferRead,
   // interrupt
   output logic rxInterrupt
);
   ////////////////////////////////////////////////////////////////////////////
   // synchronisers: first stage only feeds the second
   logic [1:0] bclkSync_q;
   logic [1:0] fsSync_q;
   logic bclkPrev_q;
   logic fsPrev_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bclkSync_q <= 2'h0;
         fsSync_q <= 2'h0;
         bclkPrev_q <= 1'b0;
         fsPrev_q <= 1'b0;
      end else begin
         bclkSync_q <= {bclkSync_q[0], rxBitClk};
         fsSync_q <= {fsSync_q[0], rxFrameSync};
         bclkPrev_q <= bclkSync_q[1];
         fsPrev_q <= fsSync_q[1];
      end
   end

   // frame sync sampled on rising bit clock edge
   logic bclkRise;
   logic fsHigh;
   logic fsStart_q;
   assign bclkRise = bclkSync_q[1] & ~bclkPrev_q;
   assign fsHigh = fsSync_q[1];

   ////////////////////////////////////////////////////////////////////////////
   // registers written by software
   logic [2:0] intEn_q;
   logic [9:0] slotsPerFrame_q;
   logic [4:0] bitsPerSlot_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         intEn_q <= 3'h0;
         slotsPerFrame_q <= arsm_pkg::SLOTS_DEFAULT;
         bitsPerSlot_q <= 5'h1f;
      end else if (bus.wr) begin
         if (bus.addr == arsm_pkg::ADDR_INT_EN) begin
            intEn_q <= bus.wdata[2:0];
         end
         if (bus.addr == arsm_pkg::ADDR_CTRL) begin
            // slot count is software's job to keep legal
            slotsPerFrame_q <= bus.wdata[9:0];
            bitsPerSlot_q <= bus.wdata[20:16];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // bit and slot counting on sampled bit clock
   logic [4:0] bitCnt_q;
   logic [9:0] slotCnt_q;
   logic inFrame_q;
   logic earlyEvt;
   logic lastBit;
   logic lastSlot;
   assign lastBit = (bitCnt_q == bitsPerSlot_q);
   assign lastSlot = (slotCnt_q == slotsPerFrame_q - 10'h001) || (slotCnt_q == arsm_pkg::SLOT_MAX);
   // sync seen before the final bit of the last slot is early
   assign earlyEvt = bclkRise & fsHigh & ~fsStart_q & inFrame_q & ~(lastSlot & lastBit);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bitCnt_q <= 5'h00;
         slotCnt_q <= arsm_pkg::SLOT_RESET;
         inFrame_q <= 1'b0;
         fsStart_q <= 1'b0;
      end else if (bclkRise) begin
         fsStart_q <= fsHigh;
         if (fsHigh & ~fsStart_q) begin
            bitCnt_q <= 5'h00;
            slotCnt_q <= arsm_pkg::SLOT_RESET;
            inFrame_q <= 1'b1;
         end else if (inFrame_q) begin
            if (lastBit) begin
               bitCnt_q <= 5'h00;
               // wraps after 383 at most
               slotCnt_q <= lastSlot ? arsm_pkg::SLOT_RESET : slotCnt_q + 10'h001;
            end else begin
               bitCnt_q <= bitCnt_q + 5'h01;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // buffer occupancy for overrun
   logic bufFull_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bufFull_q <= 1'b0;
      end else if (bufferLoad) begin
         bufFull_q <= 1'b1;
      end else if (bufferRead) begin
         bufFull_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sticky error flags
   arsm_pkg::arsm_evt_t evt;
   arsm_pkg::arsm_evt_t flags_q;
   logic statusWrite;
   assign evt.clkFail = clkFailEvt;
   assign evt.earlySync = earlyEvt;
   assign evt.overrun = bufferLoad & bufFull_q & ~bufferRead;
   assign statusWrite = bus.wr && (bus.addr == arsm_pkg::ADDR_STATUS);

   function automatic logic nextFlag(input logic cur, input logic set, input logic clr);
      // set wins so no event is lost to a racing clear
      nextFlag = set | (cur & ~clr);
   endfunction : nextFlag

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         flags_q <= arsm_pkg::FLAGS_RESET;
      end else begin
         flags_q.clkFail <= nextFlag(flags_q.clkFail, evt.clkFail,
            statusWrite & bus.wdata[arsm_pkg::BIT_CLK_FAIL]);
         flags_q.earlySync <= nextFlag(flags_q.earlySync, evt.earlySync,
            statusWrite & bus.wdata[arsm_pkg::BIT_EARLY_SYNC]);
         flags_q.overrun <= nextFlag(flags_q.overrun, evt.overrun,
            statusWrite & bus.wdata[arsm_pkg::BIT_OVERRUN]);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // status word and read port
   logic [31:0] statusWord;
   always_comb begin
      statusWord = 32'h0;
      statusWord[arsm_pkg::BIT_OVERRUN] = flags_q.overrun;
      statusWord[arsm_pkg::BIT_EARLY_SYNC] = flags_q.earlySync;
      statusWord[arsm_pkg::BIT_CLK_FAIL] = flags_q.clkFail;
      statusWord[arsm_pkg::BIT_PARITY] = slotCnt_q[0];
      statusWord[arsm_pkg::BIT_DMA_ERR] = dmaErrFlag;
      statusWord[arsm_pkg::BIT_ANY_ERR] = flags_q.overrun | flags_q.earlySync
         | flags_q.clkFail | dmaErrFlag;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata <= 32'h0;
      end else if (bus.rd) begin
         case (bus.addr)
            arsm_pkg::ADDR_STATUS: rdata <= statusWord;
            arsm_pkg::ADDR_SLOT: rdata <= {22'h0, slotCnt_q};
            arsm_pkg::ADDR_INT_EN: rdata <= {29'h0, intEn_q};
            arsm_pkg::ADDR_CTRL: rdata <= {11'h0, bitsPerSlot_q, 6'h0, slotsPerFrame_q};
            default: rdata <= 32'h0;
         endcase
      end else begin
         rdata <= 32'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // level interrupt, flags stay write-one-clear rather than clear-on-read
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rxInterrupt <= 1'b0;
      end else begin
         rxInterrupt <= |({flags_q.clkFail, flags_q.earlySync, flags_q.overrun} & intEn_q);
      end
   end
endmodule : arsm_top

/* File: verif/arsm_codec_model.sv */
`timescale 1ns/1ps
module arsm_codec_model (
   // link pins toward the block
   output logic bitClk,
   output logic frameSync
);
   // a gated codec clock idles low between frames
   initial begin
      bitClk = 1'b0;
      frameSync = 1'b0;
   end
   // sync high for the first bit only, 160 ns a bit
   task automatic frame(input int nBits);
      // step off the sampling clock edge so the synchronisers never race the pins
      #1;
      for (int i = 0; i < nBits; i++) begin
         frameSync = (i == 0);
         #80 bitClk = 1'b1;
         #80 bitClk = 1'b0;
      end
      frameSync = 1'b0;
   endtask : frame
endmodule : arsm_codec_model

/* File: verif/arsm_top_checker.sv */
`timescale 1ns/1ps
module arsm_top_checker (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // watched ports
   input wire arsm_pkg::arsm_bus_t bus,
   input wire logic [31:0] rdata,
   input wire logic clkFailEvt,
   input wire logic rxInterrupt
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////
   // bus steps that the properties are built from
   sequence s_rdStat; bus.rd && bus.addr == arsm_pkg::ADDR_STATUS; endsequence
   sequence s_rdSlot; bus.rd && bus.addr == arsm_pkg::ADDR_SLOT; endsequence
   sequence s_enWr(v); bus.wr && bus.addr == arsm_pkg::ADDR_INT_EN && bus.wdata[2:0] == v; endsequence
   sequence s_failRd; clkFailEvt ##1 !bus.wr ##1 s_rdStat; endsequence
   property p_idle; !$past(bus.rd) |-> rdata == 32'h0; endproperty
   property p_slotRsv; s_rdSlot |=> rdata[31:10] == 22'h0; endproperty
   property p_slotMax; s_rdSlot |=> rdata[9:0] <= arsm_pkg::SLOT_MAX; endproperty
   property p_statRsv; s_rdStat |=> rdata[31:9] == 23'h0 && rdata[6:4] == 3'h0; endproperty
   property p_anyErr; s_rdStat |=> rdata[8] == |{rdata[7], rdata[2:0]}; endproperty
   property p_clkFail; s_failRd |=> rdata[2]; endproperty
   // the interrupt lags the enable by two cycles, so allow three
   property p_irqOff; s_enWr(3'h0) ##1 !bus.wr [*2] |=> !rxInterrupt; endproperty
   property p_irqOn; s_enWr(3'h7) ##2 clkFailEvt ##1 !bus.wr [*3] |=> rxInterrupt; endproperty
   a_idle: assert property (p_idle) else $error("read data not zero");
   a_slotRsv: assert property (p_slotRsv) else $error("slot upper bits set");
   a_slotMax: assert property (p_slotMax) else $error("slot above top");
   a_statRsv: assert property (p_statRsv) else $error("status reserved set");
   a_anyErr: assert property (p_anyErr) else $error("summary bit wrong");
   a_clkFail: assert property (p_clkFail) else $error("clock fail not set");
   a_irqOff: assert property (p_irqOff) else $error("masked irq high");
   a_irqOn: assert property (p_irqOn) else $error("irq missing");
endmodule : arsm_top_checker
bind arsm_top arsm_top_checker u_chk (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata),
   .clkFailEvt(clkFailEvt), .rxInterrupt(rxInterrupt));

/* File: verif/tb_arsm_top.sv */
`timescale 1ns/1ps
module tb_arsm_top;
   localparam logic [3:0] ST = arsm_pkg::ADDR_STATUS;
   localparam logic [3:0] SL = arsm_pkg::ADDR_SLOT;
   localparam logic [3:0] CT = arsm_pkg::ADDR_CTRL;
   logic clk, rst, bitClk, frameSync, dmaErrFlag, rxInterrupt;
   logic [2:0] evts;
   logic [31:0] rdata;
   arsm_pkg::arsm_bus_t bus;
   int failures, compares;
   arsm_top u_dut (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata), .rxBitClk(bitClk),
      .rxFrameSync(frameSync), .clkFailEvt(evts[2]), .dmaErrFlag(dmaErrFlag),
      .bufferLoad(evts[1]), .bufferRead(evts[0]), .rxInterrupt(rxInterrupt));
   arsm_codec_model u_codec (.bitClk(bitClk), .frameSync(frameSync));
   ////////////////////////////////////////
   // one bus cycle with event pulses beside it; idle edge first avoids double drives
   task automatic put(input logic [3:0] a, input logic [31:0] v, input logic w,
      input logic [2:0] e);
      @(posedge clk);
      bus <= '{addr: a, wdata: v, wr: w, rd: 1'b0};
      evts <= e;
      @(posedge clk);
      bus <= '0;
      evts <= 3'h0;
   endtask : put
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic rc(input logic [3:0] a, input logic [31:0] exp);
      @(posedge clk);
      bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus <= '0;
      #1 chk(rdata, exp);
   endtask : rc
   ////////////////////////////////////////
   task automatic t_regs();
      put(4'h2, 32'hffffffff, 1'b1, 3'h0);
      put(SL, 32'hffffffff, 1'b1, 3'h0);
      put(arsm_pkg::ADDR_INT_EN, 32'hfffffff8, 1'b1, 3'h0);
      rc(arsm_pkg::ADDR_INT_EN, 32'h0);
      rc(4'h2, 32'h0);
      rc(SL, 32'h0);
      rc(ST, 32'h0);
      $display("t_regs done");
   endtask : t_regs
   task automatic t_clkFail();
      put(arsm_pkg::ADDR_INT_EN, 32'h0, 1'b1, 3'h0);
      put(ST, 32'h0, 1'b0, 3'h4);
      rc(ST, 32'h104);
      chk({31'h0, rxInterrupt}, 32'h0);
      put(arsm_pkg::ADDR_INT_EN, 32'h7, 1'b1, 3'h0);
      put(ST, 32'h0, 1'b0, 3'h4);
      repeat (4) @(posedge clk);
      #1 chk({31'h0, rxInterrupt}, 32'h1);
      put(ST, 32'h0, 1'b1, 3'h0);
      rc(ST, 32'h104);
      put(ST, 32'h4, 1'b1, 3'h0);
      rc(ST, 32'h0);
      repeat (2) @(posedge clk);
      #1 chk({31'h0, rxInterrupt}, 32'h0);
      @(posedge clk);
      dmaErrFlag <= 1'b1;
      rc(ST, 32'h180);
      @(posedge clk);
      dmaErrFlag <= 1'b0;
      $display("t_clkFail done");
   endtask : t_clkFail
   task automatic t_overrun();
      put(ST, 32'h0, 1'b0, 3'h2);
      rc(ST, 32'h0);
      put(ST, 32'h0, 1'b0, 3'h2);
      rc(ST, 32'h101);
      put(ST, 32'h1, 1'b1, 3'h2);
      rc(ST, 32'h101);
      // overrun masked by its own enable bit, then let through
      put(arsm_pkg::ADDR_INT_EN, 32'h6, 1'b1, 3'h0);
      repeat (2) @(posedge clk);
      #1 chk({31'h0, rxInterrupt}, 32'h0);
      put(arsm_pkg::ADDR_INT_EN, 32'h1, 1'b1, 3'h0);
      repeat (2) @(posedge clk);
      #1 chk({31'h0, rxInterrupt}, 32'h1);
      put(ST, 32'h0, 1'b0, 3'h1);
      put(ST, 32'h1, 1'b1, 3'h2);
      rc(ST, 32'h0);
      $display("t_overrun done");
   endtask : t_overrun
   // two-bit slots, two a frame, then 384 one-bit slots up to the slot limit of 383
   task automatic t_link();
      put(CT, 32'h00010002, 1'b1, 3'h0);
      rc(CT, 32'h00010002);
      u_codec.frame(3);
      rc(SL, 32'h1);
      rc(ST, 32'h8);
      u_codec.frame(4);
      rc(ST, 32'h10a);
      chk({31'h0, rxInterrupt}, 32'h0);
      put(arsm_pkg::ADDR_INT_EN, 32'h2, 1'b1, 3'h0);
      repeat (2) @(posedge clk);
      #1 chk({31'h0, rxInterrupt}, 32'h1);
      put(ST, 32'h2, 1'b1, 3'h0);
      u_codec.frame(4);
      u_codec.frame(4);
      rc(ST, 32'h8);
      put(CT, 32'h00000180, 1'b1, 3'h0);
      u_codec.frame(384);
      rc(SL, 32'h17f);
      $display("t_link done");
   endtask : t_link
   task automatic test_done();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : test_done
   ////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      #200us;
      failures++;
      test_done();
   end
   initial begin
      rst = 1'b1;
      bus = '0;
      evts = 3'h0;
      dmaErrFlag = 1'b0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_clkFail();
      t_overrun();
      t_link();
      test_done();
   end
endmodule : tb_arsm_top
